// ---- hdl/scpm_ctrl.sv ----
// Purpose: System clock selection and halt power-mode control with three control registers.
// Assumes: CPU raises halt_req for one cycle when it executes halt; wake sources are pins
//          or same-clock pulses as marked on the ports.
// Notes:   Oscillators are modelled by enables; fast RC stability is a settle counter, crystal readiness an input.
// ============================================================================
module scpm_ctrl
  import scpm_pkg::*;
#(
  parameter int SETTLE_CYC = SCPM_FAST_RC_SETTLE_CYC,
  parameter int PORTA_W    = 8
) (
  input  wire logic               mclk,
  input  wire logic               resetn,
  input  wire logic [3:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [7:0]         reg_rdata,
  input  wire logic               halt_req,
  input  wire logic               wdt_enabled,
  input  wire logic               wdt_overflow,
  input  wire logic               wdt_clear_instr,
  input  wire logic               sys_irq,
  input  wire logic [PORTA_W-1:0] porta_pin,
  input  wire logic [PORTA_W-1:0] porta_wake_en,
  input  wire logic               crystal_pins_en,
  input  wire logic               crystal_ready,
  output scpm_clk_gates_t         clk_gates,
  output logic                    sys_clk_tick,
  output logic                    hs_source_sel,
  output logic                    fast_rc_on,
  output logic                    crystal_on,
  output logic                    crystal_drive_range,
  output logic                    wdt_counter_clear,
  output logic                    power_down_flag,
  output logic                    watchdog_timeout_flag,
  output scpm_mode_t              mode
);

  // ==========================================================================
  // Registers
  logic [7:0]         scc_reg, scc_next;
  logic [7:0]         frc_reg, frc_next;
  logic [7:0]         xtc_reg, xtc_next;
  logic               pdf_reg, pdf_next;
  logic               to_reg, to_next;
  logic [7:0]         rdata_reg, rdata_next;
  logic [15:0]        settle_reg, settle_next;
  logic               wclr_reg, wclr_next;
  scpm_mode_t         mode_reg, mode_next;
  logic [PORTA_W-1:0] porta_s;
  logic [PORTA_W-1:0] porta_prev_reg;
  logic               xtal_pins_s;
  logic               xtal_ready_s;
  logic               wake;
  logic               frc_stable;
  logic               hs_run;

  // ==========================================================================
  // Synchronisers
  // Pins and the crystal status come from outside mclk, so only the second flop
  // of each pair is ever read by the logic below.
  for (genvar i = 0; i < PORTA_W; i++) begin : g_pa
    scpm_sync2 u_sync (
      .mclk   (mclk),
      .resetn (resetn),
      .d_in   (porta_pin[i]),
      .q_out  (porta_s[i])
    );
  end

  scpm_sync2 u_sync_xpin (
    .mclk   (mclk),
    .resetn (resetn),
    .d_in   (crystal_pins_en),
    .q_out  (xtal_pins_s)
  );

  scpm_sync2 u_sync_xrdy (
    .mclk   (mclk),
    .resetn (resetn),
    .d_in   (crystal_ready),
    .q_out  (xtal_ready_s)
  );

  function automatic logic wr_hit(input logic [3:0] ofs);
    return reg_wr && (reg_addr == ofs);
  endfunction

  // Picks the power-down mode from the keep-on bits as they stand at halt.
  function automatic scpm_mode_t halt_mode(input logic fast_keep, input logic slow_keep);
    case ({fast_keep, slow_keep})
      2'b00:   return SCPM_SLEEP;
      2'b01:   return SCPM_IDLE_SUB;
      2'b11:   return SCPM_IDLE_BOTH;
      default: return SCPM_IDLE_FAST;
    endcase
  endfunction

  // ==========================================================================
  // Wake sources
  // The pin flops reset low while idle pins sit high, so the first edges after
  // reset are rising ones and cannot wake the block by mistake.
  // Falling edge on an enabled synchronised port A pin, the interrupt or a watchdog overflow.
  assign wake = (|(porta_prev_reg & ~porta_s & porta_wake_en)) || sys_irq
                || wdt_overflow;

  assign frc_stable = frc_reg[SCPM_BIT_FAST_RC_STABLE];

  // ==========================================================================
  // Register and mode next state
  always_comb begin
    scc_next    = scc_reg;
    frc_next    = frc_reg;
    xtc_next    = xtc_reg;
    pdf_next    = pdf_reg;
    to_next     = to_reg;
    settle_next = settle_reg;
    mode_next   = mode_reg;
    wclr_next   = 1'b0;
    rdata_next  = 8'h00;

    if (wr_hit(SCPM_OFS_SYS_CLOCK_CTRL)) begin
      scc_next[SCPM_BIT_HS_SOURCE_SEL] = reg_wdata[SCPM_BIT_HS_SOURCE_SEL];
      scc_next[SCPM_BIT_FAST_KEEP_ON]  = reg_wdata[SCPM_BIT_FAST_KEEP_ON];
      scc_next[SCPM_BIT_SLOW_KEEP_ON]  = reg_wdata[SCPM_BIT_SLOW_KEEP_ON];
    end
    if (wr_hit(SCPM_OFS_FAST_RC_CTRL)) begin
      frc_next[SCPM_BIT_FAST_RC_ENABLE] = reg_wdata[SCPM_BIT_FAST_RC_ENABLE];
      if (reg_wdata[SCPM_BIT_FAST_RC_ENABLE]) begin
        // Every enabling write restarts the settle so software sees a fresh flag.
        frc_next[SCPM_BIT_FAST_RC_STABLE] = 1'b0;
        settle_next = 16'(SETTLE_CYC);
      end
    end
    if (wr_hit(SCPM_OFS_CRYSTAL_CTRL)) begin
      xtc_next[SCPM_BIT_CRYSTAL_ENABLE] = reg_wdata[SCPM_BIT_CRYSTAL_ENABLE];
      xtc_next[SCPM_BIT_CRYSTAL_SPARE]  = reg_wdata[SCPM_BIT_CRYSTAL_SPARE];
      // The range is locked against a running crystal, since changing the drive
      // in mid oscillation can upset its amplitude.
      if (!(xtal_pins_s && xtc_reg[SCPM_BIT_CRYSTAL_ENABLE])) begin
        xtc_next[SCPM_BIT_CRYSTAL_RANGE] = reg_wdata[SCPM_BIT_CRYSTAL_RANGE];
      end
    end

    // Fast RC settle counter; it only advances while the oscillator is running.
    // The enable is taken from its next value so that a disabling write never
    // leaves the stable flag raised for a cycle behind it.
    if (!frc_next[SCPM_BIT_FAST_RC_ENABLE] || !fast_rc_on) begin
      frc_next[SCPM_BIT_FAST_RC_STABLE] = 1'b0;
      settle_next = 16'(SETTLE_CYC);
    end else if (wr_hit(SCPM_OFS_FAST_RC_CTRL)) begin
      // An enabling write restarts the count, whatever it had reached.
      settle_next = 16'(SETTLE_CYC);
    end else if (settle_reg != 16'h0000) begin
      settle_next = settle_reg - 16'h0001;
    end else begin
      frc_next[SCPM_BIT_FAST_RC_STABLE] = 1'b1;
    end

    if (wdt_clear_instr) begin
      pdf_next = 1'b0;
    end
    if (wdt_overflow && mode_reg != SCPM_FAST) begin
      to_next = 1'b1;
    end

    case (mode_reg)
      SCPM_FAST: begin
        if (halt_req) begin
          // Keep-on bits are taken as they stand when halt executes.
          mode_next = halt_mode(scc_reg[SCPM_BIT_FAST_KEEP_ON],
                                scc_reg[SCPM_BIT_SLOW_KEEP_ON]);
          pdf_next  = 1'b1;
          to_next   = 1'b0;
          wclr_next = 1'b1;
        end
      end
      SCPM_SLEEP, SCPM_IDLE_SUB, SCPM_IDLE_BOTH, SCPM_IDLE_FAST: begin
        if (wake) begin
          mode_next = SCPM_WAKE_WAIT;
        end
      end
      SCPM_WAKE_WAIT: begin
        if (hs_source_sel ? xtal_ready_s : frc_stable) begin
          mode_next = SCPM_FAST;
        end
      end
      default: mode_next = SCPM_FAST;
    endcase

    // Read data is zero outside the cycle after a read, so an OR of several
    // register slaves on one bus stays clean.
    if (reg_rd) begin
      case (reg_addr)
        SCPM_OFS_SYS_CLOCK_CTRL: rdata_next = scc_reg & 8'h0B;
        SCPM_OFS_FAST_RC_CTRL:   rdata_next = frc_reg & 8'h03;
        SCPM_OFS_CRYSTAL_CTRL:   rdata_next = xtc_reg & 8'h07;
        SCPM_OFS_PWR_STATUS:     rdata_next = {6'h00, to_reg, pdf_reg};
        default:                 rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      scc_reg        <= SCPM_RST_SYS_CLOCK_CTRL;
      frc_reg        <= SCPM_RST_FAST_RC_CTRL;
      xtc_reg        <= SCPM_RST_CRYSTAL_CTRL;
      pdf_reg        <= 1'b0;
      to_reg         <= 1'b0;
      settle_reg     <= 16'(SETTLE_CYC);
      wclr_reg       <= 1'b0;
      rdata_reg      <= 8'h00;
      mode_reg       <= SCPM_FAST;
      porta_prev_reg <= '0;
    end else begin
      scc_reg        <= scc_next;
      frc_reg        <= frc_next;
      xtc_reg        <= xtc_next;
      pdf_reg        <= pdf_next;
      to_reg         <= to_next;
      settle_reg     <= settle_next;
      wclr_reg       <= wclr_next;
      rdata_reg      <= rdata_next;
      mode_reg       <= mode_next;
      porta_prev_reg <= porta_s;
    end
  end

  // ==========================================================================
  // Clock gating per mode
  always_comb begin
    clk_gates = '0;
    case (mode_reg)
      // Wake wait runs every clock so the fast RC can settle, but the CPU stays
      // stopped until the selected source is ready.
      SCPM_FAST, SCPM_WAKE_WAIT: begin
        clk_gates = '{cpu_run: (mode_reg == SCPM_FAST), sys_clk_en: 1'b1,
                      fast_clk_en: 1'b1, sub_clk_en: 1'b1, slow_rc_en: 1'b1};
      end
      SCPM_SLEEP: clk_gates.slow_rc_en = wdt_enabled;
      SCPM_IDLE_SUB: begin
        clk_gates.sub_clk_en = 1'b1;
        clk_gates.slow_rc_en = 1'b1;
      end
      SCPM_IDLE_BOTH: begin
        clk_gates = '{cpu_run: 1'b0, sys_clk_en: 1'b1, fast_clk_en: 1'b1,
                      sub_clk_en: 1'b1, slow_rc_en: 1'b1};
      end
      SCPM_IDLE_FAST: begin
        clk_gates = '{cpu_run: 1'b0, sys_clk_en: 1'b1, fast_clk_en: 1'b1,
                      sub_clk_en: 1'b0, slow_rc_en: 1'b1};
      end
      default: clk_gates = '0;
    endcase
  end

  // The CPU stalls on the halt instruction while cpu_run is low.
  assign hs_run = clk_gates.fast_clk_en;

  // ==========================================================================
  // System clock divider

  scpm_clk_div #(
    .DIV (SCPM_SYS_CLK_DIV)
  ) u_div (
    .mclk   (mclk),
    .resetn (resetn),
    .run    (hs_run && clk_gates.sys_clk_en),
    .tick   (sys_clk_tick)
  );

  assign hs_source_sel       = scc_reg[SCPM_BIT_HS_SOURCE_SEL];
  // Oscillators stop in halt unless the fast keep-on bit holds them.
  assign fast_rc_on          = frc_reg[SCPM_BIT_FAST_RC_ENABLE] && hs_run;
  assign crystal_on          = xtc_reg[SCPM_BIT_CRYSTAL_ENABLE] && hs_run;
  assign crystal_drive_range = xtc_reg[SCPM_BIT_CRYSTAL_RANGE];
  assign wdt_counter_clear   = wclr_reg;
  assign power_down_flag     = pdf_reg;
  assign watchdog_timeout_flag = to_reg;
  assign reg_rdata           = rdata_reg;
  assign mode                = mode_reg;

endmodule // scpm_ctrl

// ---- hdl/scpm_pkg.sv ----
// Purpose: Shared constants and types for the system clock and power mode controller.
// Assumes: 8-bit register port, mclk at 20 MHz.
// Notes:   Register offsets are local choices; bit positions follow the register layout.
package scpm_pkg;

  // ==========================================================================
  // Register map
  localparam logic [3:0] SCPM_OFS_SYS_CLOCK_CTRL = 4'h0;
  localparam logic [3:0] SCPM_OFS_FAST_RC_CTRL   = 4'h1;
  localparam logic [3:0] SCPM_OFS_CRYSTAL_CTRL   = 4'h2;
  localparam logic [3:0] SCPM_OFS_PWR_STATUS     = 4'h3;

  // ==========================================================================
  // Field positions
  localparam int SCPM_BIT_HS_SOURCE_SEL     = 3;
  localparam int SCPM_BIT_FAST_KEEP_ON      = 1;
  localparam int SCPM_BIT_SLOW_KEEP_ON      = 0;
  localparam int SCPM_BIT_FAST_RC_STABLE    = 1;
  localparam int SCPM_BIT_FAST_RC_ENABLE    = 0;
  localparam int SCPM_BIT_CRYSTAL_RANGE     = 2;
  localparam int SCPM_BIT_CRYSTAL_SPARE     = 1;
  localparam int SCPM_BIT_CRYSTAL_ENABLE    = 0;
  localparam int SCPM_BIT_POWER_DOWN_FLAG   = 0;
  localparam int SCPM_BIT_WDT_TIMEOUT_FLAG  = 1;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] SCPM_RST_SYS_CLOCK_CTRL = 8'h00;
  localparam logic [7:0] SCPM_RST_FAST_RC_CTRL   = 8'h01;
  localparam logic [7:0] SCPM_RST_CRYSTAL_CTRL   = 8'h00;

  // ==========================================================================
  // Timing
  localparam int SCPM_CLK_HZ            = 20_000_000;
  localparam int SCPM_FAST_RC_SETTLE_US = 16;
  localparam int SCPM_FAST_RC_SETTLE_CYC =
    (SCPM_FAST_RC_SETTLE_US * (SCPM_CLK_HZ / 1_000_000) < 1) ? 1 :
    SCPM_FAST_RC_SETTLE_US * (SCPM_CLK_HZ / 1_000_000);
  localparam int SCPM_SYS_CLK_DIV       = 2;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    SCPM_FAST,
    SCPM_SLEEP,
    SCPM_IDLE_SUB,
    SCPM_IDLE_BOTH,
    SCPM_IDLE_FAST,
    SCPM_WAKE_WAIT
  } scpm_mode_t;

  typedef struct packed {
    logic cpu_run;
    logic sys_clk_en;
    logic fast_clk_en;
    logic sub_clk_en;
    logic slow_rc_en;
  } scpm_clk_gates_t;

endpackage : scpm_pkg

// ---- hdl/scpm_sync2.sv ----
// Purpose: Two-flop synchroniser for a level from outside the mclk domain.
// Assumes: Input is a slow level.
// Notes:   Only the second flop is visible to logic.
module scpm_sync2 (
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic d_in,
  output logic      q_out
);

  logic meta_reg;
  logic q_reg;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= 1'b0;
      q_reg    <= 1'b0;
    end else begin
      meta_reg <= d_in;
      q_reg    <= meta_reg;
    end
  end

  assign q_out = q_reg;

endmodule // scpm_sync2

// ---- hdl/scpm_clk_div.sv ----
// Purpose: Divides the selected high-speed clock rate into a system clock enable.
// Assumes: Enable input is high while the high-speed clock runs.
// Notes:   One-cycle pulse every DIV cycles; the counter restarts when stopped.
module scpm_clk_div #(
  parameter int DIV = 2
) (
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic run,
  output logic      tick
);

  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    if (!run) begin
      cnt_next = 8'h00;
    end else if (cnt_reg == 8'(DIV - 1)) begin
      cnt_next = 8'h00;
    end else begin
      cnt_next = cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign tick = run && (cnt_reg == 8'(DIV - 1));

endmodule // scpm_clk_div

// ---- verif/scpm_ctrl_checker.sv ----
// Purpose: Port-level assertions for the clock and power mode controller.
// Assumes: One mclk domain; resetn asynchronous, active low.
// Notes:   Gate patterns follow the struct order cpu, sys, fast, sub, slow.
module scpm_ctrl_checker
  import scpm_pkg::*;
(
  input wire logic            mclk,
  input wire logic            resetn,
  input wire logic            reg_rd,
  input wire logic [7:0]      reg_rdata,
  input wire logic            halt_req,
  input wire logic            wdt_enabled,
  input wire scpm_clk_gates_t clk_gates,
  input wire logic            sys_clk_tick,
  input wire logic            fast_rc_on,
  input wire logic            wdt_counter_clear,
  input wire logic            power_down_flag,
  input wire logic            watchdog_timeout_flag,
  input wire scpm_mode_t      mode
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // ==========================================================================
  // Halt entry
  sequence halt_taken;
    halt_req && mode == SCPM_FAST;
  endsequence
  sequence halt_done;
    mode != SCPM_FAST && power_down_flag && !watchdog_timeout_flag;
  endsequence
  a_halt_enters: assert property (halt_taken |=> halt_done)
    else $error("halt did not enter a power-down mode with flags");
  a_wdt_clear: assert property (halt_taken |=> wdt_counter_clear)
    else $error("watchdog clear missing after halt");
  // ==========================================================================
  // Clock gates per mode
  a_fast_gates: assert property (mode == SCPM_FAST |-> clk_gates == 5'h1F)
    else $error("fast mode gates wrong");
  a_sleep_gates: assert property (mode == SCPM_SLEEP |->
    clk_gates[4:1] == 4'h0 && clk_gates.slow_rc_en == wdt_enabled)
    else $error("sleep gates wrong");
  a_sub_gates: assert property (mode == SCPM_IDLE_SUB |-> clk_gates == 5'h03)
    else $error("sub idle gates wrong");
  a_both_gates: assert property (mode == SCPM_IDLE_BOTH |-> clk_gates == 5'h0F)
    else $error("both idle gates wrong");
  a_fastonly_gates: assert property (mode == SCPM_IDLE_FAST |-> clk_gates == 5'h0D)
    else $error("fast idle gates wrong");
  // ==========================================================================
  // Divider, oscillator and read port
  a_tick_gap: assert property (sys_clk_tick |=> !sys_clk_tick)
    else $error("system tick faster than half rate");
  a_tick_runs: assert property (clk_gates.fast_clk_en [*3] |->
    sys_clk_tick || $past(sys_clk_tick))
    else $error("system tick missing while fast clock runs");
  a_rc_gated: assert property (fast_rc_on |-> clk_gates.fast_clk_en)
    else $error("fast RC on while fast clock stopped");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
endmodule // scpm_ctrl_checker

bind scpm_ctrl scpm_ctrl_checker i_scpm_ctrl_checker (.mclk(mclk), .resetn(resetn),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .halt_req(halt_req), .wdt_enabled(wdt_enabled),
  .clk_gates(clk_gates), .sys_clk_tick(sys_clk_tick), .fast_rc_on(fast_rc_on),
  .wdt_counter_clear(wdt_counter_clear), .power_down_flag(power_down_flag),
  .watchdog_timeout_flag(watchdog_timeout_flag), .mode(mode));

// ---- verif/scpm_ctrl_tb.sv ----
// Purpose: Self-checking bench for the clock and power mode controller.
// Assumes: Short settle count of 4 cycles to keep the run brief.
// Notes:   Inputs change by non-blocking assignment at rising edges.
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module scpm_ctrl_tb
  import scpm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, halt_req = 0, wdt_enabled = 0;
  logic wdt_overflow = 0, wdt_clear_instr = 0, sys_irq = 0, crystal_pins_en = 0;
  logic crystal_ready = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, porta_pin = 8'hFF, porta_wake_en = 8'h01, reg_rdata;
  logic hs_source_sel, fast_rc_on, crystal_on, crystal_drive_range, wdt_counter_clear;
  logic sys_clk_tick, power_down_flag, watchdog_timeout_flag;
  scpm_clk_gates_t clk_gates;
  scpm_mode_t      mode;
  int n_errors = 0, n_compared = 0, ticks;
  scpm_mode_t exp_mode [4] = '{SCPM_SLEEP, SCPM_IDLE_SUB, SCPM_IDLE_FAST, SCPM_IDLE_BOTH};
  logic [4:0] exp_gate [4] = '{5'h01, 5'h03, 5'h0D, 5'h0F};
  scpm_ctrl #(.SETTLE_CYC(4), .PORTA_W(8)) i_scpm_ctrl (.mclk(mclk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .halt_req(halt_req), .wdt_enabled(wdt_enabled),
    .wdt_overflow(wdt_overflow), .wdt_clear_instr(wdt_clear_instr), .sys_irq(sys_irq),
    .porta_pin(porta_pin), .porta_wake_en(porta_wake_en), .crystal_pins_en(crystal_pins_en),
    .crystal_ready(crystal_ready), .clk_gates(clk_gates), .sys_clk_tick(sys_clk_tick),
    .hs_source_sel(hs_source_sel), .fast_rc_on(fast_rc_on), .crystal_on(crystal_on),
    .crystal_drive_range(crystal_drive_range), .wdt_counter_clear(wdt_counter_clear),
    .power_down_flag(power_down_flag), .watchdog_timeout_flag(watchdog_timeout_flag),
    .mode(mode));
  always #25 mclk = ~mclk;
  // ==========================================================================
  // Access tasks
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk); reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge mclk); reg_wr <= 1'b0; #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge mclk); reg_addr <= a; reg_rd <= 1'b1;
    @(posedge mclk); reg_rd <= 1'b0; #1;
    `CHK("reg_rdata", e, reg_rdata)
  endtask
  task automatic halt();
    @(posedge mclk); halt_req <= 1'b1;
    @(posedge mclk); halt_req <= 1'b0; #1;
  endtask
  // Sources: 1 interrupt, 2 watchdog overflow, others a port pin falling edge.
  task automatic wake(input int src);
    @(posedge mclk);
    if (src == 1) sys_irq <= 1'b1; else if (src == 2) wdt_overflow <= 1'b1;
    else porta_pin <= 8'hFE;
    @(posedge mclk); wdt_overflow <= 1'b0;
    for (int i = 0; i < 60 && mode !== SCPM_FAST; i++) @(posedge mclk);
    sys_irq <= 1'b0; porta_pin <= 8'hFF; #1;
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========================================================================
  // Tests
  initial begin
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    rd(SCPM_OFS_FAST_RC_CTRL, 8'h01);
    repeat (8) @(posedge mclk);
    rd(SCPM_OFS_FAST_RC_CTRL, 8'h03);
    rd(SCPM_OFS_SYS_CLOCK_CTRL, SCPM_RST_SYS_CLOCK_CTRL);
    rd(SCPM_OFS_CRYSTAL_CTRL, SCPM_RST_CRYSTAL_CTRL);
    rd(4'hF, 8'h00);
    $display("test reset values done");
    wr(SCPM_OFS_SYS_CLOCK_CTRL, 8'hFF);
    rd(SCPM_OFS_SYS_CLOCK_CTRL, 8'h0B);
    `CHK("hs_source_sel", 1'b1, hs_source_sel)
    wr(SCPM_OFS_SYS_CLOCK_CTRL, 8'h00);
    `CHK("hs_source_sel", 1'b0, hs_source_sel)
    // Four system periods plus the switch slack, in mclk cycles.
    repeat (10) @(posedge mclk);
    ticks = 0;
    for (int i = 0; i < 20; i++) begin
      @(posedge mclk); #1 ticks += (sys_clk_tick === 1'b1);
    end
    `CHK("ticks", 20 / SCPM_SYS_CLK_DIV, ticks)
    $display("test clock select done");
    @(posedge mclk);
    crystal_ready <= 1'b1;
    wr(SCPM_OFS_CRYSTAL_CTRL, 8'hFD);
    rd(SCPM_OFS_CRYSTAL_CTRL, 8'h05);
    `CHK("crystal_drive_range", 1'b1, crystal_drive_range)
    `CHK("crystal_on", 1'b1, crystal_on)
    wr(SCPM_OFS_CRYSTAL_CTRL, 8'h00);
    @(posedge mclk);
    crystal_pins_en <= 1'b1;
    repeat (4) @(posedge mclk);
    wr(SCPM_OFS_CRYSTAL_CTRL, 8'h01);
    wr(SCPM_OFS_CRYSTAL_CTRL, 8'h05);
    rd(SCPM_OFS_CRYSTAL_CTRL, 8'h01);
    @(posedge mclk);
    crystal_pins_en <= 1'b0;
    repeat (4) @(posedge mclk);
    wr(SCPM_OFS_CRYSTAL_CTRL, 8'h05);
    rd(SCPM_OFS_CRYSTAL_CTRL, 8'h05);
    wr(SCPM_OFS_CRYSTAL_CTRL, 8'h00);
    $display("test crystal control done");
    wr(SCPM_OFS_FAST_RC_CTRL, 8'h00);
    rd(SCPM_OFS_FAST_RC_CTRL, 8'h00);
    `CHK("fast_rc_on", 1'b0, fast_rc_on)
    wr(SCPM_OFS_FAST_RC_CTRL, 8'h01);
    rd(SCPM_OFS_FAST_RC_CTRL, 8'h01);
    repeat (8) @(posedge mclk);
    rd(SCPM_OFS_FAST_RC_CTRL, 8'h03);
    // A second enabling write while already stable must restart the settle.
    wr(SCPM_OFS_FAST_RC_CTRL, 8'h01);
    rd(SCPM_OFS_FAST_RC_CTRL, 8'h01);
    repeat (8) @(posedge mclk);
    rd(SCPM_OFS_FAST_RC_CTRL, 8'h03);
    $display("test fast RC done");
    for (int k = 0; k < 4; k++) begin
      @(posedge mclk);
      wdt_enabled <= (k == 0);
      wr(SCPM_OFS_SYS_CLOCK_CTRL, 8'(k));
      halt();
      `CHK("mode", exp_mode[k], mode)
      `CHK("clk_gates", exp_gate[k], clk_gates)
      `CHK("wdt_counter_clear", 1'b1, wdt_counter_clear)
      `CHK("power_down_flag", 1'b1, power_down_flag)
      `CHK("watchdog_timeout_flag", 1'b0, watchdog_timeout_flag)
      wr(SCPM_OFS_SYS_CLOCK_CTRL, 8'h03);
      `CHK("mode held", exp_mode[k], mode)
      wake(k);
      `CHK("mode woken", SCPM_FAST, mode)
      `CHK("timeout after wake", 1'(k == 2), watchdog_timeout_flag)
      rd(SCPM_OFS_FAST_RC_CTRL, 8'h03);
    end
    rd(SCPM_OFS_PWR_STATUS, 8'h01);
    @(posedge mclk); wdt_clear_instr <= 1'b1;
    @(posedge mclk); wdt_clear_instr <= 1'b0;
    rd(SCPM_OFS_PWR_STATUS, 8'h00);
    $display("test power modes done");
    tally_and_finish();
  end
  // A hang past this span counts as a mismatch.
  initial begin
    #(50 * 4000);
    n_errors++;
    tally_and_finish();
  end
endmodule // scpm_ctrl_tb
